// ==== core/tps_top.sv ====
// Purpose: power-state, gain and status registers of a three-input touch sensor
// Assumes: sensing-side inputs are on clk; register port driven by the serial bus engine
// Notes: read data appears one cycle after reg_rd; alert_n is active low
`timescale 1ns/1ps
// Functional notes
// - deep sleep, mixed, standby, active by priority
// - gain codes 0-3 give 1,2,4,8
// - mixed state uses mixed gain for standby
// - gain change restarts full calibration
// - standby scans standby inputs, holds status
// - deep sleep stops scan, clears status
// - mixed scans active and standby inputs
// - pending flag drives alert low
// - disabled channel touch raises no interrupt
// - host writes zero clears flag, alert
// - base count flag follows enabled inputs
// - calibration fail flag follows enabled inputs
// - held button sets flag and interrupt
// - multi-touch block never interrupts
// - pattern flag interrupts only when enabled
// - touch summary is OR of inputs
// - per-input touch bits in low three
// - still-touched bit stays, no reassert
// - reset loads default register values
module tps_top #(
  parameter int NIN = tps_pkg::NUM_INPUTS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [NIN-1:0] touch_det,
  input wire logic [NIN-1:0] active_en,
  input wire logic [NIN-1:0] standby_en,
  input wire logic [NIN-1:0] chan_irq_en,
  input wire logic base_count_limit,
  input wire logic analog_cal_fail,
  input wire logic button_held,
  input wire logic button_touched,
  input wire logic multi_touch_block,
  input wire logic pattern_hit,
  input wire logic pattern_irq_enable,
  output logic alert_n,
  output logic [1:0] power_state,
  output logic [3:0] gain_active,
  output logic [3:0] gain_standby,
  output logic [NIN-1:0] scan_en,
  output logic recal_req
);
  // --------------------------------------------------------------
  // control register
  // --------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic wr_ctrl;
  logic clr_req;
  logic irq_set;
  logic deep_sleep_enable;
  logic [NIN-1:0] touch_eff_r;
  logic [NIN-1:0] touch_eff_nxt;
  logic [NIN-1:0] touch_new;
  logic button_prev_r;
  logic pattern_prev_r;
  logic button_new;
  logic pattern_new;
  logic [NIN-1:0] tstat;
  logic button_flag;
  logic pattern_flag;

  assign wr_ctrl = reg_wr && (reg_addr == tps_pkg::OFS_CTRL);
  assign deep_sleep_enable = ctrl_r[tps_pkg::CTRL_DEEP_SLEEP_ENABLE];
  // host clears the pending flag by writing a zero into it
  assign clr_req = wr_ctrl && !reg_wdata[tps_pkg::CTRL_INT] && ctrl_r[tps_pkg::CTRL_INT];

  // only a fresh touch interrupts, so a held touch cannot re-raise it
  assign touch_new = touch_eff_nxt & ~touch_eff_r;
  assign button_new = button_held && !button_prev_r;
  assign pattern_new = pattern_hit && !pattern_prev_r;

  assign irq_set = !deep_sleep_enable && ((|(touch_new & chan_irq_en)) || button_new || (pattern_new && pattern_irq_enable));

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      // pending bit is hardware-set; a write can only clear it
      ctrl_nxt[7:1] = reg_wdata[7:1];
      ctrl_nxt[tps_pkg::CTRL_INT] = ctrl_r[tps_pkg::CTRL_INT] && reg_wdata[tps_pkg::CTRL_INT];
    end
    if (irq_set) begin
      ctrl_nxt[tps_pkg::CTRL_INT] = 1'b1;
    end
    if (deep_sleep_enable) begin
      ctrl_nxt[tps_pkg::CTRL_INT] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= tps_pkg::RST_CTRL;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // --------------------------------------------------------------
  // power state, scanning and gain
  // --------------------------------------------------------------
  tps_pkg::tps_pstate_e pstate;
  logic [NIN-1:0] scan_nxt;
  logic [3:0] gain_pri;
  logic [3:0] gain_mix;
  logic [3:0] gain_sby_nxt;
  logic recal_nxt;
  logic [1:0] pstate_r;
  logic [3:0] gain_act_r;
  logic [3:0] gain_sby_r;
  logic [NIN-1:0] scan_r;
  logic recal_r;
  logic alert_n_r;

  tps_gain_dec u_gain_pri (
    .code(ctrl_r[tps_pkg::CTRL_GAIN_HI:tps_pkg::CTRL_GAIN_LO]),
    .gain(gain_pri)
  );

  tps_gain_dec u_gain_mix (
    .code(ctrl_r[tps_pkg::CTRL_CGAIN_HI:tps_pkg::CTRL_CGAIN_LO]),
    .gain(gain_mix)
  );

  always_comb begin
    if (deep_sleep_enable) begin
      pstate = tps_pkg::TPS_DEEP_SLEEP_ENABLE;
    end else if (ctrl_r[tps_pkg::CTRL_COMBO]) begin
      pstate = tps_pkg::TPS_MIXED;
    end else if (ctrl_r[tps_pkg::CTRL_STANDBY_ENABLE]) begin
      pstate = tps_pkg::TPS_STANDBY;
    end else begin
      pstate = tps_pkg::TPS_ACTIVE;
    end
    unique case (pstate)
      tps_pkg::TPS_ACTIVE: scan_nxt = active_en;
      tps_pkg::TPS_STANDBY: scan_nxt = standby_en;
      tps_pkg::TPS_MIXED: scan_nxt = active_en | standby_en;
      tps_pkg::TPS_DEEP_SLEEP_ENABLE: scan_nxt = '0;
    endcase
    gain_sby_nxt = (pstate == tps_pkg::TPS_MIXED) ? gain_mix : gain_pri;
    recal_nxt = wr_ctrl && ((reg_wdata[7:6] != ctrl_r[7:6]) || (reg_wdata[3:2] != ctrl_r[3:2]));
    touch_eff_nxt = touch_det & scan_nxt;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pstate_r <= tps_pkg::TPS_ACTIVE;
      gain_act_r <= 4'h1;
      gain_sby_r <= 4'h1;
      scan_r <= '0;
      recal_r <= 1'b0;
      alert_n_r <= 1'b1;
      touch_eff_r <= '0;
      button_prev_r <= 1'b0;
      pattern_prev_r <= 1'b0;
    end else if (ce) begin
      pstate_r <= pstate;
      gain_act_r <= gain_pri;
      gain_sby_r <= gain_sby_nxt;
      scan_r <= scan_nxt;
      recal_r <= recal_nxt;
      alert_n_r <= !ctrl_nxt[tps_pkg::CTRL_INT];
      touch_eff_r <= touch_eff_nxt;
      button_prev_r <= button_held;
      pattern_prev_r <= pattern_hit;
    end
  end

  // --------------------------------------------------------------
  // status flags
  // --------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_touch
      tps_sticky u_touch (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .set(touch_eff_nxt[gi]),
        .clr_req(clr_req),
        .cond(touch_eff_nxt[gi]),
        .flush(deep_sleep_enable),
        .flag(tstat[gi])
      );
    end
  endgenerate

  tps_sticky u_button (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .set(button_new),
    .clr_req(clr_req),
    .cond(button_touched),
    .flush(deep_sleep_enable),
    .flag(button_flag)
  );

  tps_sticky u_pattern (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .set(pattern_new),
    .clr_req(clr_req),
    .cond(pattern_hit),
    .flush(deep_sleep_enable),
    .flag(pattern_flag)
  );

  // --------------------------------------------------------------
  // register read port
  // --------------------------------------------------------------
  logic [7:0] gstat;
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;

  always_comb begin
    gstat = 8'h00;
    gstat[tps_pkg::GST_BASE_COUNT_LIMIT_FLAG] = base_count_limit && !deep_sleep_enable;
    gstat[tps_pkg::GST_CAL_FAIL] = analog_cal_fail && !deep_sleep_enable;
    gstat[tps_pkg::GST_BUTTON] = button_flag;
    gstat[tps_pkg::GST_MULTI] = multi_touch_block && !deep_sleep_enable;
    gstat[tps_pkg::GST_PATTERN] = pattern_flag;
    gstat[tps_pkg::GST_TOUCH] = |tstat;
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        tps_pkg::OFS_CTRL: rdata_nxt = ctrl_r;
        tps_pkg::OFS_GSTAT: rdata_nxt = gstat;
        tps_pkg::OFS_TSTAT: rdata_nxt = {{(8 - NIN){1'b0}}, tstat};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (ce) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign alert_n = alert_n_r;
  assign power_state = pstate_r;
  assign gain_active = gain_act_r;
  assign gain_standby = gain_sby_r;
  assign scan_en = scan_r;
  assign recal_req = recal_r;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_DEEP_SLEEP_ENABLE_PRIO: assert property (ce && deep_sleep_enable |=> power_state == 2'h3)
    else $error("deep sleep not selected");
  AST_MIXED_STATE: assert property (ce && !deep_sleep_enable && ctrl_r[1] |=> power_state == 2'h2)
    else $error("mixed state not selected");
  AST_GAIN_ACT: assert property (ce |=> gain_active == (4'h1 << $past(ctrl_r[7:6])))
    else $error("primary gain wrong");
  AST_GAIN_SBY: assert property (ce && !deep_sleep_enable && ctrl_r[1] |=> gain_standby == (4'h1 << $past(ctrl_r[3:2])))
    else $error("mixed gain not applied");
  AST_RECAL: assert property (ce && wr_ctrl && reg_wdata[7:6] != ctrl_r[7:6] |=> recal_req)
    else $error("gain change without recalibration");
  AST_STANDBY_ENABLE_SCAN: assert property (ce && ctrl_r[5:4] == 2'h2 && !ctrl_r[1] |=> scan_en == $past(standby_en))
    else $error("standby scan set wrong");
  AST_DEEP_SLEEP_ENABLE_CLR: assert property (ce && deep_sleep_enable |=> tstat == '0 && !ctrl_r[0] && alert_n)
    else $error("deep sleep left status set");
  AST_ALERT: assert property (ce |=> alert_n == !ctrl_r[0])
    else $error("alert does not follow pending flag");
  AST_NO_IRQ: assert property (ce && !ctrl_r[0] && !irq_set |=> !ctrl_r[0])
    else $error("pending flag without enabled source");
  AST_INT_CLEAR: assert property (ce && clr_req && !irq_set |=> !ctrl_r[0])
    else $error("pending flag not cleared by host");
  AST_TOUCH_SUM: assert property (gstat[0] == (|tstat))
    else $error("touch summary mismatch");
  AST_HELD_TOUCH: assert property (ce && clr_req && !deep_sleep_enable && touch_eff_nxt[0] |=> tstat[0])
    else $error("held touch bit lost");

  COV_TOUCH_IRQ: cover property (ce && touch_new[0] && chan_irq_en[0] && !deep_sleep_enable ##1 ctrl_r[0]);
  COV_HOST_CLEAR: cover property (ce && clr_req ##1 !ctrl_r[0]);
  COV_DEEP_SLEEP_ENABLE: cover property (ce && deep_sleep_enable && ctrl_r[0]);
  COV_GAIN_RECAL: cover property (recal_req);
endmodule

// ==== core/tps_pkg.sv ====
// Purpose: shared constants for the touch power-state and status register bank
// Assumes: 8-bit registers, three sensor inputs
// Notes: offsets and bit positions as seen by the host
package tps_pkg;
  localparam int NUM_INPUTS = 3;
  // --------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_GSTAT = 8'h02;
  localparam logic [7:0] OFS_TSTAT = 8'h03;
  // --------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_GSTAT = 8'h00;
  localparam logic [7:0] RST_TSTAT = 8'h00;
  // --------------------------------------------------------------
  // control register fields
  // --------------------------------------------------------------
  localparam int CTRL_GAIN_HI = 7;
  localparam int CTRL_GAIN_LO = 6;
  localparam int CTRL_STANDBY_ENABLE = 5;
  localparam int CTRL_DEEP_SLEEP_ENABLE = 4;
  localparam int CTRL_CGAIN_HI = 3;
  localparam int CTRL_CGAIN_LO = 2;
  localparam int CTRL_COMBO = 1;
  localparam int CTRL_INT = 0;
  // --------------------------------------------------------------
  // general status fields
  // --------------------------------------------------------------
  localparam int GST_BASE_COUNT_LIMIT_FLAG = 6;
  localparam int GST_CAL_FAIL = 5;
  localparam int GST_BUTTON = 4;
  localparam int GST_MULTI = 2;
  localparam int GST_PATTERN = 1;
  localparam int GST_TOUCH = 0;
  // --------------------------------------------------------------
  // power states
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    TPS_ACTIVE = 2'b00,
    TPS_STANDBY = 2'b01,
    TPS_MIXED = 2'b10,
    TPS_DEEP_SLEEP_ENABLE = 2'b11
  } tps_pstate_e;
endpackage

// ==== core/tps_gain_dec.sv ====
// Purpose: decode a two-bit gain code into a one-hot gain multiplier
// Assumes: codes 0..3 map to gains 1, 2, 4, 8
// Notes: purely combinational
`timescale 1ns/1ps
module tps_gain_dec (
  input wire logic [1:0] code,
  output logic [3:0] gain
);
  always_comb begin
    unique case (code)
      2'h0: gain = 4'h1;
      2'h1: gain = 4'h2;
      2'h2: gain = 4'h4;
      2'h3: gain = 4'h8;
    endcase
  end
endmodule

// ==== core/tps_sticky.sv ====
// Purpose: one status flag, set by an event, cleared on request once its cause is gone
// Assumes: flush has priority over everything, set wins over clear
// Notes: state frozen while ce is low
`timescale 1ns/1ps
module tps_sticky (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic set,
  input wire logic clr_req,
  input wire logic cond,
  input wire logic flush,
  output logic flag
);
  logic flag_r;
  logic flag_nxt;

  always_comb begin
    flag_nxt = flag_r;
    if (flush) begin
      flag_nxt = 1'b0;
    end else if (set) begin
      flag_nxt = 1'b1;
    end else if (clr_req && !cond) begin
      flag_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else if (ce) begin
      flag_r <= flag_nxt;
    end
  end

  assign flag = flag_r;
endmodule

// ==== bench/tps_host_model.sv ====
// Purpose: host side of the register port
// Assumes: strobes change on the falling edge
// Notes: one access at a time, data inverted when idle
`timescale 1ns/1ps
module tps_host_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // ------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------
  // write strobe held one cycle, data inverted after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  // data stands one cycle only, so taken at once
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    d = reg_rdata;
    reg_rd = 1'b0;
  endtask
endmodule

// ==== bench/testbench.sv ====
// Purpose: self-checking bench for the power-state and status bank
// Assumes: ce high except one freeze check, inputs change on the falling edge
// Notes: expectations built from bit positions, never from outputs
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, alert_n, recal_req;
  logic [2:0] touch_det = 3'h0;
  logic [2:0] active_en = 3'h7;
  logic [2:0] standby_en = 3'h0;
  logic [2:0] chan_irq_en = 3'h7;
  logic bcl = 1'b0, acf = 1'b0, bh = 1'b0, bt = 1'b0, mtb = 1'b0, ph = 1'b0, pie = 1'b0;
  logic [1:0] power_state;
  logic [3:0] gain_active, gain_standby;
  logic [2:0] scan_en;
  int bad_count = 0;
  int tests_run = 0;
  always #4 clk = ~clk;
  tps_host_model u_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  tps_top #(.NIN(3)) u_dut (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .touch_det(touch_det),
    .active_en(active_en), .standby_en(standby_en), .chan_irq_en(chan_irq_en),
    .base_count_limit(bcl), .analog_cal_fail(acf), .button_held(bh), .button_touched(bt),
    .multi_touch_block(mtb), .pattern_hit(ph), .pattern_irq_enable(pie), .alert_n(alert_n),
    .power_state(power_state), .gain_active(gain_active), .gain_standby(gain_standby),
    .scan_en(scan_en), .recal_req(recal_req));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, d);
    chk(d, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // bounded look for the one-cycle recalibration pulse
  task automatic wait_recal(output logic seen);
    seen = 1'b0;
    for (int k = 0; k < 6; k++) begin
      if (recal_req === 1'b1) seen = 1'b1;
      @(negedge clk);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rchk(8'h00, 8'h00);
    rchk(8'h02, 8'h00);
    rchk(8'h03, 8'h00);
    chk({7'h00, alert_n}, 8'h01);
    chk({4'h0, gain_active}, 8'h01);
    u_host.wr(8'h02, 8'hFF);
    u_host.wr(8'h03, 8'hFF);
    rchk(8'h02, 8'h00);
    rchk(8'h03, 8'h00);
    rchk(8'h7A, 8'h00);
    // frozen clock enable must keep the default
    ce = 1'b0;
    u_host.wr(8'h00, 8'h40);
    ce = 1'b1;
    rchk(8'h00, 8'h00);
    // second reset in mid-run
    u_host.wr(8'h00, 8'hC0);
    tick(2);
    chk({4'h0, gain_active}, 8'h08);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    rchk(8'h00, 8'h00);
    chk({4'h0, gain_active}, 8'h01);
  endtask
  task automatic t_pstate();
    logic [7:0] c;
    logic [1:0] e;
    for (int i = 0; i < 8; i++) begin
      c = {2'b00, i[2], i[1], 2'b00, i[0], 1'b0};
      e = i[1] ? 2'h3 : (i[0] ? 2'h2 : (i[2] ? 2'h1 : 2'h0));
      u_host.wr(8'h00, c);
      tick(2);
      chk({6'h00, power_state}, {6'h00, e});
      rchk(8'h00, c);
    end
  endtask
  task automatic t_gain();
    logic [1:0] g;
    logic seen;
    for (int k = 0; k < 4; k++) begin
      g = 2'(k + 1);
      u_host.wr(8'h00, {g, 6'h00});
      wait_recal(seen);
      chk({7'h00, seen}, 8'h01);
      if (!seen) stop_test();
      chk({4'h0, gain_active}, 8'h01 << g);
      chk({4'h0, gain_standby}, 8'h01 << g);
    end
    // same value again must not restart calibration
    u_host.wr(8'h00, 8'h00);
    wait_recal(seen);
    chk({7'h00, seen}, 8'h00);
    for (int k = 0; k < 4; k++) begin
      g = 2'(k);
      u_host.wr(8'h00, {4'h4, g, 2'b10});
      tick(3);
      chk({4'h0, gain_active}, 8'h02);
      chk({4'h0, gain_standby}, 8'h01 << g);
    end
  endtask
  task automatic t_scan();
    active_en = 3'b101;
    standby_en = 3'b010;
    u_host.wr(8'h00, 8'h20);
    tick(2);
    chk({5'h00, scan_en}, 8'h02);
    u_host.wr(8'h00, 8'h02);
    tick(2);
    chk({5'h00, scan_en}, 8'h07);
    active_en = 3'h7;
    standby_en = 3'h0;
    u_host.wr(8'h00, 8'h00);
  endtask
  task automatic t_touch();
    for (int i = 0; i < 3; i++) begin
      touch_det = 3'(1 << i);
      tick(3);
      rchk(8'h03, 8'(1 << i));
      rchk(8'h02, 8'h01);
      chk({7'h00, alert_n}, 8'h00);
      rchk(8'h00, 8'h01);
      touch_det = 3'h0;
      u_host.wr(8'h00, 8'h00);
      tick(1);
      chk({7'h00, alert_n}, 8'h01);
      rchk(8'h03, 8'h00);
    end
  endtask
  task automatic t_hold();
    touch_det = 3'h1;
    tick(3);
    u_host.wr(8'h00, 8'h00);
    tick(4);
    chk({7'h00, alert_n}, 8'h01);
    rchk(8'h03, 8'h01);
    touch_det = 3'h0;
    chan_irq_en = 3'h0;
    tick(1);
    touch_det = 3'h2;
    tick(3);
    chk({7'h00, alert_n}, 8'h01);
    rchk(8'h00, 8'h00);
    touch_det = 3'h0;
    chan_irq_en = 3'h7;
  endtask
  task automatic t_sleep();
    bh = 1'b1;
    tick(2);
    chk({7'h00, alert_n}, 8'h00);
    u_host.wr(8'h00, 8'h11);
    bh = 1'b0;
    tick(2);
    chk({7'h00, alert_n}, 8'h01);
    chk({5'h00, scan_en}, 8'h00);
    rchk(8'h02, 8'h00);
    rchk(8'h03, 8'h00);
    rchk(8'h00, 8'h10);
    touch_det = 3'h1;
    tick(3);
    chk({7'h00, alert_n}, 8'h01);
    touch_det = 3'h0;
    u_host.wr(8'h00, 8'h00);
  endtask
  task automatic t_general();
    bcl = 1'b1;
    acf = 1'b1;
    mtb = 1'b1;
    tick(2);
    rchk(8'h02, 8'h64);
    chk({7'h00, alert_n}, 8'h01);
    bcl = 1'b0;
    acf = 1'b0;
    tick(2);
    rchk(8'h02, 8'h04);
    mtb = 1'b0;
    ph = 1'b1;
    tick(2);
    rchk(8'h02, 8'h02);
    chk({7'h00, alert_n}, 8'h01);
    ph = 1'b0;
    pie = 1'b1;
    tick(1);
    ph = 1'b1;
    tick(2);
    chk({7'h00, alert_n}, 8'h00);
    ph = 1'b0;
    u_host.wr(8'h00, 8'h00);
    rchk(8'h02, 8'h00);
    bh = 1'b1;
    bt = 1'b1;
    tick(2);
    rchk(8'h02, 8'h10);
    // button still touched at the clear keeps its flag
    bh = 1'b0;
    u_host.wr(8'h00, 8'h00);
    rchk(8'h02, 8'h10);
    // pattern still present at the clear keeps its flag
    bt = 1'b0;
    ph = 1'b1;
    tick(2);
    u_host.wr(8'h00, 8'h00);
    rchk(8'h02, 8'h02);
    ph = 1'b0;
    bh = 1'b1;
    tick(2);
    bh = 1'b0;
    u_host.wr(8'h00, 8'h00);
    rchk(8'h02, 8'h00);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_pstate();
    t_gain();
    t_scan();
    t_touch();
    t_hold();
    t_sleep();
    t_general();
    stop_test();
  end
endmodule
